// ===== hdl/pbmc_port_ctrl.sv
// Port A/B/I/D/P logic with the multiplexed external memory bus engine.
// Assumes one 100 MHz clock, synchronous pin inputs and a register
// port with read data one cycle after the read strobe.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "pbmc_cfg.svh"

module pbmc_port_ctrl (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst,
    input  wire logic [3:0]                i_reg_addr,
    input  wire logic [15:0]               i_reg_wdata,
    input  wire logic                      i_reg_wr,
    input  wire logic                      i_reg_rd,
    input  wire logic                      i_reg_byte,
    output logic      [15:0]               o_reg_rdata,
    input  wire logic                      i_mem_valid,
    input  wire pbmc_pkg::pbmc_mem_req_type i_mem_req,
    output logic                           o_mem_done,
    output logic      [15:0]               o_mem_rdata,
    input  wire logic                      i_external_memory_pin,
    input  wire logic                      i_ready_or_hold_n,
    output logic                           o_hold_ack,
    input  wire logic [15:0]               i_pa,
    output logic      [15:0]               o_pa,
    output logic      [15:0]               o_pa_oe,
    input  wire logic [15:0]               i_pb,
    output logic      [15:0]               o_pb,
    output logic      [15:0]               o_pb_oe,
    input  wire logic [15:0]               i_b_alt_out,
    input  wire logic [15:0]               i_b_alt_oe,
    input  wire logic [7:0]                i_pi,
    output pbmc_pkg::pbmc_i_feed_type      o_i_feed,
    input  wire logic [7:0]                i_pd,
    input  wire logic [3:0]                i_timer_out,
    output logic      [3:0]                o_pp,
    output logic      [3:0]                o_pp_oe,
    output logic                           o_half_rate_clock_out,
    output logic                           o_inverted_clock_out,
    output pbmc_pkg::pbmc_mode_type        o_mode
);

    // Pin read: data register where driven, pin level where input
    function automatic logic [15:0] pin_read(
        input logic [15:0] dir,
        input logic [15:0] data,
        input logic [15:0] pin
    );
        pin_read = (dir & data) | (~dir & pin);
    endfunction

    logic [15:0] a_data_r;
    logic [15:0] a_dir_r;
    logic [15:0] b_data_r;
    logic [15:0] b_dir_r;
    logic [15:0] b_alt_r;
    logic [3:0]  p_data_r;
    logic [3:0]  p_sel_r;
    logic [1:0]  ctrl_r;
    logic        bus8_r;
    logic        strap_done_r;
    logic        ports_on_r;
    logic        half_r;
    logic        hold_ack_r;
    logic        off_chip_r;
    logic [15:0] rdata_r;
    logic [15:0] mem_rdata_r;
    logic        mem_done_r;
    pbmc_pkg::pbmc_mem_req_type req_r;
    pbmc_pkg::pbmc_i_feed_type  feed_r;
    pbmc_pkg::pbmc_state_type   st_r;
    pbmc_pkg::pbmc_state_type   st_nxt;

    // Mode decode and address map
    wire ea_w = ctrl_r[`PBMC_CTRL_EA];
    wire hold_sel_w = ctrl_r[`PBMC_CTRL_HOLD];
    wire exm_w = i_external_memory_pin;
    wire ext_w = ea_w | exm_w;
    wire ram_hit_w = i_mem_req.addr <= `PBMC_RAM_TOP;
    wire rom_hit_w = i_mem_req.addr >= `PBMC_ROM_BASE;
    // ROM space goes out when the pin is high; RAM always stays inside
    wire off_w = !ram_hit_w && (ea_w ? (exm_w || !rom_hit_w)
                                     : (exm_w && rom_hit_w));
    assign o_mode = pbmc_pkg::pbmc_mode_type'({exm_w, ea_w});

    // Register port decode
    wire wr_a_w   = i_reg_wr && i_reg_addr == `PBMC_A_DATA;
    wire wr_ad_w  = i_reg_wr && i_reg_addr == `PBMC_A_DIR;
    wire wr_b_w   = i_reg_wr && i_reg_addr == `PBMC_B_DATA;
    wire wr_bd_w  = i_reg_wr && i_reg_addr == `PBMC_B_DIR;
    wire wr_bf_w  = i_reg_wr && i_reg_addr == `PBMC_B_ALT;
    wire wr_p_w   = i_reg_wr && i_reg_addr == `PBMC_P_DATA;
    wire wr_ps_w  = i_reg_wr && i_reg_addr == `PBMC_P_SEL;
    wire wr_c_w   = i_reg_wr && i_reg_addr == `PBMC_CTRL;
    logic [15:0] rd_mux_w;
    always_comb
    begin
        case (i_reg_addr)
            `PBMC_A_DATA: rd_mux_w = pin_read(a_dir_r, a_data_r, i_pa);
            `PBMC_A_DIR:  rd_mux_w = a_dir_r;
            `PBMC_B_DATA: rd_mux_w = pin_read(b_dir_r, b_data_r, i_pb);
            `PBMC_B_DIR:  rd_mux_w = b_dir_r;
            `PBMC_B_ALT:  rd_mux_w = b_alt_r;
            `PBMC_P_DATA: rd_mux_w = {12'h000, p_data_r};
            `PBMC_P_SEL:  rd_mux_w = {12'h000, p_sel_r};
            `PBMC_I_IN:   rd_mux_w = {8'h00, i_pi};
            `PBMC_D_IN:   rd_mux_w = {8'h00, i_pd};
            `PBMC_CTRL:   rd_mux_w = {14'h0000, ctrl_r};
            `PBMC_STAT:   rd_mux_w = {12'h000, hold_ack_r, bus8_r, exm_w, ea_w};
            default:      rd_mux_w = 16'h0000;
        endcase
    end
    // Byte format returns only the low byte
    wire [15:0] rd_fmt_w = i_reg_byte ? {8'h00, rd_mux_w[7:0]} : rd_mux_w;

    // Software registers, all cleared so port A and B pins start as floating inputs when the memory pin is low
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            a_data_r <= `PBMC_RST_VAL;
            a_dir_r  <= `PBMC_RST_VAL;
            b_data_r <= `PBMC_RST_VAL;
            b_dir_r  <= `PBMC_RST_VAL;
            b_alt_r  <= `PBMC_RST_VAL;
            p_data_r <= 4'h0;
            p_sel_r  <= 4'h0;
            ctrl_r   <= 2'h0;
            rdata_r  <= 16'h0000;
        end
        else
        begin
            if (wr_a_w)  a_data_r <= i_reg_wdata;
            if (wr_ad_w) a_dir_r  <= i_reg_wdata;
            if (wr_b_w)  b_data_r <= i_reg_wdata;
            if (wr_bd_w) b_dir_r  <= i_reg_wdata;
            if (wr_bf_w) b_alt_r  <= i_reg_wdata;
            if (wr_p_w)  p_data_r <= i_reg_wdata[3:0];
            if (wr_ps_w) p_sel_r  <= i_reg_wdata[3:0];
            if (wr_c_w)  ctrl_r   <= i_reg_wdata[1:0];
            if (i_reg_rd) rdata_r <= rd_fmt_w;
        end
    end
    assign o_reg_rdata = rdata_r;

    // Strap capture one edge after release; async reset takes constants
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            strap_done_r <= 1'b0;
            bus8_r       <= 1'b0;
            ports_on_r   <= 1'b0;
        end
        else
        begin
            strap_done_r <= 1'b1;
            ports_on_r   <= 1'b1;
            if (!strap_done_r) bus8_r <= i_pb[`PBMC_B_HBE];
        end
    end

    // Bus engine: latch phase, strobe phase, finish
    wire hold_req_w = hold_sel_w && !i_ready_or_hold_n;
    wire wait_w = !hold_sel_w && !i_ready_or_hold_n;
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            pbmc_pkg::PBMC_IDLE:
                if (i_mem_valid && ext_w && !hold_ack_r && !hold_req_w)
                    st_nxt = pbmc_pkg::PBMC_ADDR;
            pbmc_pkg::PBMC_ADDR: st_nxt = pbmc_pkg::PBMC_STRB;
            pbmc_pkg::PBMC_STRB:
                if (!wait_w) st_nxt = pbmc_pkg::PBMC_DONE;
            pbmc_pkg::PBMC_DONE: st_nxt = pbmc_pkg::PBMC_IDLE;
            default: st_nxt = pbmc_pkg::PBMC_IDLE;
        endcase
    end

    // Request capture, hold grant and read data capture
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r        <= pbmc_pkg::PBMC_IDLE;
            req_r       <= '0;
            off_chip_r  <= 1'b0;
            hold_ack_r  <= 1'b0;
            mem_rdata_r <= 16'h0000;
            mem_done_r  <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            if (st_r == pbmc_pkg::PBMC_IDLE && i_mem_valid)
            begin
                req_r      <= i_mem_req;
                off_chip_r <= off_w;
            end
            // Hold is granted only between bus cycles
            if (st_r == pbmc_pkg::PBMC_IDLE) hold_ack_r <= hold_req_w;
            mem_done_r <= st_r == pbmc_pkg::PBMC_STRB && !wait_w;
            if (st_r == pbmc_pkg::PBMC_STRB && !wait_w && !req_r.wr)
                mem_rdata_r <= i_pa;
        end
    end
    assign o_mem_done  = mem_done_r;
    assign o_mem_rdata = mem_rdata_r;
    assign o_hold_ack  = hold_ack_r;

    // Active-low strobes and active-high ALE, only for off-chip cycles
    wire in_addr_w = st_r == pbmc_pkg::PBMC_ADDR;
    wire in_strb_w = st_r == pbmc_pkg::PBMC_STRB;
    wire rd_n_w  = !(in_strb_w && off_chip_r && !req_r.wr);
    wire wr_n_w  = !(in_strb_w && off_chip_r && req_r.wr);
    wire hbe_n_w = !(in_strb_w && off_chip_r && !bus8_r);
    wire ale_w   = in_addr_w && off_chip_r;
    wire bus_on_w = ext_w && !hold_ack_r;
    wire a_drive_w = in_addr_w || (in_strb_w && req_r.wr);
    wire [15:0] a_bus_w = in_addr_w ? req_r.addr : req_r.wdata;

    // Port A: bus owner in external modes, plain port otherwise
    assign o_pa = ext_w ? a_bus_w : a_data_r;
    assign o_pa_oe = !ports_on_r ? 16'h0000 :
                     ext_w ? {16{bus_on_w && a_drive_w && off_chip_r}}
                           : a_dir_r;

    // Port B: data, alternate function, then bus control pins on top
    logic [15:0] b_out_w;
    logic [15:0] b_oe_w;
    always_comb
    begin
        b_out_w = (b_alt_r & i_b_alt_out) | (~b_alt_r & b_data_r);
        b_oe_w  = (b_alt_r & i_b_alt_oe) | (~b_alt_r & b_dir_r);
        if (ext_w)
        begin
            b_out_w[`PBMC_B_ALE] = ale_w;
            b_out_w[`PBMC_B_WR]  = wr_n_w;
            b_out_w[`PBMC_B_RD]  = rd_n_w;
            b_oe_w[`PBMC_B_ALE]  = bus_on_w;
            b_oe_w[`PBMC_B_WR]   = bus_on_w;
            b_oe_w[`PBMC_B_RD]   = bus_on_w;
            if (!bus8_r)
            begin
                b_out_w[`PBMC_B_HBE] = hbe_n_w;
                b_oe_w[`PBMC_B_HBE]  = bus_on_w;
            end
        end
    end
    assign o_pb    = b_out_w;
    assign o_pb_oe = ports_on_r ? b_oe_w : 16'h0000;

    // Port P: timer output or data per pin
    assign o_pp    = (p_sel_r & i_timer_out) | (~p_sel_r & p_data_r);
    assign o_pp_oe = {4{ports_on_r}};

    // Port I feeds, registered to keep outputs from flops
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            feed_r <= '0;
        else
            feed_r <= {i_pi[1], i_pi[4:2], i_pi[5], i_pi[6]};
    end
    assign o_i_feed = feed_r;

    // Clock outputs; the inverted copy is a plain gate on the clock
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            half_r <= 1'b0;
        else
            half_r <= !half_r;
    end
    assign o_half_rate_clock_out = half_r;
    assign o_inverted_clock_out  = ~i_clk_sys;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_port_d_read: assert property (
        i_reg_rd && i_reg_addr == `PBMC_D_IN
        |=> o_reg_rdata == {8'h00, $past(i_pd)})
        else $error("port D read wrong");
    a_byte_format: assert property (
        i_reg_rd && i_reg_byte |=> o_reg_rdata[15:8] == 8'h00)
        else $error("byte read has upper bits");
    a_input_float: assert property (
        ports_on_r && !ext_w && !a_dir_r[0] |-> !o_pa_oe[0])
        else $error("input pin driven");
    a_bus_addr: assert property (
        in_addr_w && off_chip_r && bus_on_w |-> o_pa == req_r.addr && o_pa_oe == 16'hFFFF)
        else $error("address not on port A");
    a_strobe_off: assert property (
        !rd_n_w || !wr_n_w |-> off_chip_r && $past(in_addr_w || in_strb_w))
        else $error("strobe for internal address");
    // Checked at the pin, so a lost override in the port B mux shows up
    a_hbe_width: assert property (
        in_strb_w && off_chip_r && bus_on_w && !bus8_r
        |-> !o_pb[`PBMC_B_HBE] && o_pb_oe[`PBMC_B_HBE])
        else $error("byte enable missing on 16-bit bus");
    // Gated by ports_on_r so the last reset edge is never compared
    a_half_clock: assert property (
        ports_on_r |-> o_half_rate_clock_out != $past(o_half_rate_clock_out))
        else $error("half rate clock stuck");
    a_ready_wait: assert property (
        in_strb_w && wait_w |=> in_strb_w && !o_mem_done)
        else $error("wait not honoured");
    a_reset_float: assert property (
        !ports_on_r |-> o_pa_oe == 16'h0000 && o_pb_oe == 16'h0000
                        && o_pp_oe == 4'h0)
        else $error("port driven in reset");
    a_alt_select: assert property (
        b_alt_r[0] |-> o_pb[0] == i_b_alt_out[0])
        else $error("alternate function not passed");

    c_ext_write: cover property (in_strb_w && !wr_n_w ##1 o_mem_done);
    c_ext_read: cover property (in_strb_w && !rd_n_w ##1 o_mem_done);
    c_wait: cover property (in_strb_w && wait_w [*2]);
    c_hold: cover property ($rose(hold_ack_r));

endmodule

// ===== shared/pbmc_cfg.svh
// Register map, pin positions and reset values of the port block.
// Assumes inclusion by the design module, the memory model and the bench.
`ifndef PBMC_CFG_SVH
`define PBMC_CFG_SVH
`define PBMC_A_DATA   4'h0
`define PBMC_A_DIR    4'h1
`define PBMC_B_DATA   4'h2
`define PBMC_B_DIR    4'h3
`define PBMC_B_ALT    4'h4
`define PBMC_P_DATA   4'h5
`define PBMC_P_SEL    4'h6
`define PBMC_I_IN     4'h7
`define PBMC_D_IN     4'h8
`define PBMC_CTRL     4'h9
`define PBMC_STAT     4'hA
`define PBMC_CTRL_EA   0
`define PBMC_CTRL_HOLD 1
`define PBMC_B_ALE    10
`define PBMC_B_WR     11
`define PBMC_B_HBE    12
`define PBMC_B_RD     15
`define PBMC_RST_VAL  16'h0000
`define PBMC_RAM_TOP  16'h00FF
`define PBMC_ROM_BASE 16'hF000
`endif

// ===== shared/pbmc_pkg.sv
// Types shared by the port and bus mode block.
// Assumes the constants header sits beside it.
package pbmc_pkg;
    typedef enum logic [1:0] {
        PBMC_SINGLE, PBMC_EXPANDED, PBMC_SINGLE_NOROM, PBMC_EXPANDED_NOROM
    } pbmc_mode_type;
    typedef enum logic [1:0] {
        PBMC_IDLE, PBMC_ADDR, PBMC_STRB, PBMC_DONE
    } pbmc_state_type;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
    } pbmc_mem_req_type;
    typedef struct packed {
        logic       nmi;
        logic [2:0] capture;
        logic       serial_in;
        logic       uart_receive_in;
    } pbmc_i_feed_type;
endpackage

// ===== tb/pbmc_ext_mem.sv
// Behavioural external memory on the multiplexed address/data bus.
// Assumes resolved pin levels and a select line from the bench.
`include "pbmc_cfg.svh"
module pbmc_ext_mem (
    input  wire logic        i_clk_sys,
    input  wire logic        i_sel,
    input  wire integer      i_waits,
    input  wire logic [15:0] i_pa,
    input  wire logic [15:0] i_pb,
    output logic      [15:0] o_pa,
    output logic             o_pa_drive,
    output logic             o_ready_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];
    logic [15:0] addr_r;
    logic        wr_now;
    logic        rd_now;
    int          wait_cnt = 0;
    int          strobes = 0;
    int          hbes = 0;
    // Strobes are active low and only seen while this device is selected
    assign wr_now     = i_sel && !i_pb[`PBMC_B_WR];
    assign rd_now     = i_sel && !i_pb[`PBMC_B_RD];
    assign o_pa_drive = rd_now;
    assign o_pa       = mem[addr_r[7:0]]; // Only 256 words kept, upper bits alias
    // Slow answer: ready held low for the first i_waits edges of a strobe
    assign o_ready_n  = !((wr_now || rd_now) && wait_cnt < i_waits);
    // Address on the latch pulse, data while the write strobe is low
    always @(posedge i_clk_sys)
    begin
        if (i_sel && i_pb[`PBMC_B_ALE])
            addr_r <= i_pa;
        if (wr_now)
            mem[addr_r[7:0]] <= i_pa;
        if (wr_now || rd_now)
        begin
            strobes <= strobes + 1;
            hbes    <= hbes + int'(!i_pb[`PBMC_B_HBE]);
        end
        wait_cnt <= (wr_now || rd_now) ? wait_cnt + 1 : 0;
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the port block, its registers and memory engine.
// Assumes the package, constants header and memory model compiled first.
`include "pbmc_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk = 1'b0;
    logic                       rst = 1'b1;
    logic [3:0]                 ra = 4'h0;
    logic [15:0]                wd = 16'h0000;
    logic                       wr = 1'b0, rds = 1'b0, byt = 1'b0, mv = 1'b0;
    logic                       ext = 1'b0, hold_n = 1'b1, sel = 1'b0;
    pbmc_pkg::pbmc_mem_req_type mreq = '0;
    logic [15:0]                tpa = 16'h0000, tpb = 16'h8800, aout = 16'h0000;
    logic [15:0]                aoe = 16'h0000;
    logic [7:0]                 pi = 8'h00, pd = 8'h00;
    logic [3:0]                 tmr = 4'h0, pp, pp_oe;
    logic [15:0]                rdat, mrd, pa, pa_oe, pb, pb_oe, pa_pin, pb_pin, mpa;
    logic                       done, hack, half, inv, mdrv, mrdy_n, h;
    pbmc_pkg::pbmc_i_feed_type  feed;
    pbmc_pkg::pbmc_mode_type    mode;
    logic [15:0]                rd, d, dir, dat, alt, eoe, m;
    logic [15:0]                exp_q[$];
    int                         n, s0, b0, waits = 0, miscompares = 0, check_count = 0;
    integer                     seed;
    // Pin level: design driver first, then the memory, then the bench
    assign pa_pin = (pa_oe & pa) | (~pa_oe & (mdrv ? mpa : tpa));
    assign pb_pin = (pb_oe & pb) | (~pb_oe & tpb);
    always #5 clk = ~clk;
    pbmc_port_ctrl dut_u (
        .i_clk_sys(clk), .i_rst(rst), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
        .i_reg_rd(rds), .i_reg_byte(byt), .o_reg_rdata(rdat), .i_mem_valid(mv),
        .i_mem_req(mreq), .o_mem_done(done), .o_mem_rdata(mrd),
        .i_external_memory_pin(ext), .i_ready_or_hold_n(hold_n & mrdy_n),
        .o_hold_ack(hack), .i_pa(pa_pin), .o_pa(pa), .o_pa_oe(pa_oe), .i_pb(pb_pin),
        .o_pb(pb), .o_pb_oe(pb_oe), .i_b_alt_out(aout), .i_b_alt_oe(aoe), .i_pi(pi),
        .o_i_feed(feed), .i_pd(pd), .i_timer_out(tmr), .o_pp(pp), .o_pp_oe(pp_oe),
        .o_half_rate_clock_out(half), .o_inverted_clock_out(inv), .o_mode(mode)
    );
    pbmc_ext_mem mem_u (
        .i_clk_sys(clk), .i_sel(sel), .i_waits(waits), .i_pa(pa_pin), .i_pb(pb_pin),
        .o_pa(mpa), .o_pa_drive(mdrv), .o_ready_n(mrdy_n)
    );
    task automatic end_of_test();
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Four-state compare so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        ra <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands from the cycle after the strobe until the next read
    task automatic reg_read(input logic [3:0] a, input logic b, output logic [15:0] v);
        @(posedge clk);
        ra  <= a;
        byt <= b;
        rds <= 1'b1;
        @(posedge clk);
        rds <= 1'b0;
        #1;
        v = rdat;
    endtask
    // One request; n counts edges from the take to the done pulse
    task automatic mem_op(input logic [15:0] a, input logic [15:0] v, input logic w);
        @(posedge clk);
        mv   <= 1'b1;
        mreq <= '{addr: a, wdata: v, wr: w};
        @(posedge clk);
        mv <= 1'b0;
        n = 0;
        while (n < 20 && done !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    // Strap level is held through the release of reset
    task automatic do_reset(input logic strap);
        @(posedge clk);
        tpb[`PBMC_B_HBE] <= strap;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(pa_oe | pb_oe | {12'h000, pp_oe}, 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        seed = 32'h4ECED551;
        do_reset(1'b0);
        chk(pa_oe | pb_oe, 16'h0000);
        reg_read(`PBMC_B_ALT, 1'b0, rd);
        chk(rd, 16'h0000);
        chk({12'h000, pp_oe}, 16'h000F);
        // Port A with random directions, data and pin levels
        repeat (4)
        begin
            @(posedge clk);
            tpa <= $random(seed);
            dir = $random(seed);
            dat = $random(seed);
            reg_write(`PBMC_A_DIR, dir);
            reg_write(`PBMC_A_DATA, dat);
            reg_read(`PBMC_A_DATA, 1'b0, rd);
            m = (dir & dat) | (~dir & tpa);
            chk(rd, m);
            chk(pa_oe, dir);
            chk(pa & dir, dat & dir);
            reg_read(`PBMC_A_DATA, 1'b1, rd);
            chk(rd, {8'h00, m[7:0]});
        end
        // Port B; bus pins kept primary, their alternate use is not modelled
        repeat (3)
        begin
            @(posedge clk);
            tpb  <= $random(seed);
            aout <= $random(seed);
            aoe  <= $random(seed);
            dir = $random(seed);
            dat = $random(seed);
            alt = $random(seed) & 16'h63FF;
            reg_write(`PBMC_B_DIR, dir);
            reg_write(`PBMC_B_DATA, dat);
            reg_write(`PBMC_B_ALT, alt);
            reg_read(`PBMC_B_DATA, 1'b0, rd);
            chk(rd & ~alt, ((dir & dat) | (~dir & tpb)) & ~alt);
            eoe = (alt & aoe) | (~alt & dir);
            chk(pb_oe, eoe);
            chk(pb & eoe, ((alt & aout) | (~alt & dat)) & eoe);
        end
        reg_write(`PBMC_B_ALT, 16'h0000);
        reg_write(`PBMC_B_DIR, 16'h0000);
        reg_write(`PBMC_A_DIR, 16'h0000);
        // Input ports, feed taps, port P source and refused accesses
        @(posedge clk);
        tpb <= 16'h8800;
        pi  <= $random(seed);
        pd  <= $random(seed);
        tmr <= $random(seed);
        dat = $random(seed);
        alt = $random(seed);
        reg_write(`PBMC_P_DATA, dat);
        reg_write(`PBMC_P_SEL, alt);
        reg_write(`PBMC_I_IN, 16'hFFFF);
        reg_read(`PBMC_I_IN, 1'b0, rd);
        chk(rd, {8'h00, pi});
        reg_read(`PBMC_D_IN, 1'b0, rd);
        chk(rd, {8'h00, pd});
        chk({10'h000, feed}, {10'h000, pi[1], pi[4:2], pi[5], pi[6]});
        chk({12'h000, pp}, {12'h000, (alt[3:0] & tmr) | (~alt[3:0] & dat[3:0])});
        reg_write(4'hB, 16'hFFFF);
        reg_read(4'hB, 1'b0, rd);
        chk(rd, 16'h0000);
        // Clock outputs
        h = half;
        @(posedge clk);
        #1;
        chk({15'h0000, half}, {15'h0000, ~h});
        chk({15'h0000, inv}, {15'h0000, ~clk});
        // All four modes from the pin and the access bit
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            ext <= k[1];
            reg_write(`PBMC_CTRL, {15'h0000, k[0]});
            reg_read(`PBMC_STAT, 1'b0, rd);
            chk({14'h0000, mode}, 16'(k));
            chk({14'h0000, rd[1:0]}, 16'(k));
        end
        // Single chip refuses the engine
        @(posedge clk);
        ext <= 1'b0;
        sel <= 1'b1;
        reg_write(`PBMC_CTRL, 16'h0000);
        mem_op(16'h1234, 16'h0000, 1'b1);
        chk(16'(n), 16'h0014);
        // Expanded: prompt write, slow read back, silent internal RAM
        reg_write(`PBMC_CTRL, 16'h0001);
        d = $random(seed);
        s0 = mem_u.strobes;
        b0 = mem_u.hbes;
        mem_op(16'h1234, d, 1'b1);
        exp_q.push_back(d);
        chk(16'(n), 16'h0002);
        chk(16'(mem_u.strobes - s0), 16'h0001);
        chk(16'(mem_u.hbes - b0), 16'h0001);
        @(posedge clk);
        waits <= 2;
        tpa   <= ~d;
        mem_op(16'h1234, 16'h0000, 1'b0);
        chk(16'(n), 16'h0004);
        chk(mrd, exp_q.pop_front());
        s0 = mem_u.strobes;
        mem_op(16'h0040, d, 1'b1);
        chk(16'(mem_u.strobes - s0), 16'h0000);
        // Memory pin high: ROM space external, RAM internal
        @(posedge clk);
        ext   <= 1'b1;
        waits <= 0;
        reg_write(`PBMC_CTRL, 16'h0000);
        s0 = mem_u.strobes;
        mem_op(16'hF010, d, 1'b1);
        chk(16'(mem_u.strobes - s0), 16'h0001);
        mem_op(16'h0020, d, 1'b1);
        chk(16'(mem_u.strobes - s0), 16'h0001);
        // Hold use releases the bus while requested
        @(posedge clk);
        ext <= 1'b0;
        reg_write(`PBMC_CTRL, 16'h0003);
        @(posedge clk);
        hold_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, hack}, 16'h0001);
        chk(pa_oe, 16'h0000);
        @(posedge clk);
        hold_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, hack}, 16'h0000);
        // Second reset with the strap high: byte bus, no byte enable
        reg_write(`PBMC_A_DIR, 16'hFFFF);
        do_reset(1'b1);
        reg_read(`PBMC_A_DIR, 1'b0, rd);
        chk(rd, 16'h0000);
        reg_write(`PBMC_CTRL, 16'h0001);
        reg_read(`PBMC_STAT, 1'b0, rd);
        chk({15'h0000, rd[2]}, 16'h0001);
        b0 = mem_u.hbes;
        mem_op(16'h2222, d, 1'b1);
        chk(16'(n), 16'h0002);
        chk(16'(mem_u.hbes - b0), 16'h0000);
        // Stack words kept in internal RAM never reach the byte bus
        s0 = mem_u.strobes;
        mem_op(16'h0080, d, 1'b1);
        chk(16'(n), 16'h0002);
        chk(16'(mem_u.strobes - s0), 16'h0000);
        end_of_test();
    end
    // Watchdog well beyond the expected run length
    initial
    begin
        #200000;
        miscompares++;
        end_of_test();
    end
endmodule
